// ### verilog/mcpce_pkg.sv
// Package with the register map, field layout, event codes and carrier types of the counter block.
package mcpce_pkg;

	// Register map: four control words, then four counters, one aligned word each.
	localparam int              MCPCE_NUM_CNT    = 4;
	localparam logic [5:0]      MCPCE_OFS_CTL0   = 6'h00;
	localparam logic [5:0]      MCPCE_OFS_CTR0   = 6'h10;
	localparam logic [5:0]      MCPCE_OFS_END    = 6'h20;

	// Control word field positions.
	localparam int              MCPCE_CODE_LSB   = 0;
	localparam int              MCPCE_UMASK_LSB  = 8;
	localparam int              MCPCE_EDGE_BIT   = 18;
	localparam int              MCPCE_EN_BIT     = 22;
	localparam int              MCPCE_INV_BIT    = 23;
	localparam logic [31:0]     MCPCE_CTL_WMASK  = 32'h00C4_FFFF;

	// Values after reset.
	localparam logic [31:0]     MCPCE_CTL_RST    = 32'h0000_0000;
	localparam logic [31:0]     MCPCE_CNT_RST    = 32'h0000_0000;

	// Event codes.
	localparam logic [7:0]      MCPCE_EV_PRE     = 8'h02;
	localparam logic [7:0]      MCPCE_EV_PREEMPT = 8'h08;
	localparam logic [7:0]      MCPCE_EV_THROT   = 8'h41;
	localparam logic [7:0]      MCPCE_EV_LIMIT   = 8'h42;
	localparam logic [7:0]      MCPCE_EV_SELFREF = 8'h43;
	localparam logic [7:0]      MCPCE_EV_CKE     = 8'h83;
	localparam logic [7:0]      MCPCE_EV_CRIT    = 8'h86;
	localparam logic [7:0]      MCPCE_EV_PRIO    = 8'hA0;
	localparam logic [7:0]      MCPCE_EV_RANK0   = 8'hB0;

	// Unit mask bits and values.
	localparam int              MCPCE_READ_OVER_READ_SEL  = 0;
	localparam int              MCPCE_READ_OVER_WRITE_SEL = 1;
	localparam int              MCPCE_FAST_PATH_SEL       = 4;
	localparam int              MCPCE_STARVED_PRIORITY_SEL = 3;
	localparam logic [7:0]      MCPCE_UM_BANK_LAST = 8'h0F;
	localparam logic [7:0]      MCPCE_EVERY_BANK_SEL = 8'h10;
	localparam logic [7:0]      MCPCE_BANK_GROUP_SEL = 8'h11;
	localparam logic [7:0]      MCPCE_UM_GROUP_LAST  = 8'h14;

	// Decoded control word.
	typedef struct packed {
		logic       inv;
		logic       en;
		logic       edge_det;
		logic [7:0] umask;
		logic [7:0] code;
	} mcpce_ctl_t;

	// Per-cycle status and command strobes from the controller.
	typedef struct packed {
		logic [7:0] cke_on;
		logic       crit_throttle;
		logic       power_ctrl_limit_event;
		logic       self_refresh_clk;
		logic [7:0] throttle_rank;
		logic       rd_preempts_rd;
		logic       rd_preempts_wr;
		logic       pre_strobe;
		logic [4:0] pre_cause;
		logic       pre_auto;
		logic       cas_strobe;
		logic [3:0] cas_prio;
		logic [2:0] cas_rank;
		logic [3:0] cas_bank;
	} mcpce_status_t;

endpackage

// ### verilog/mcpce_evsel.sv
// Event selector: turns one control word and the controller status into a count condition.
`timescale 1ns/1ns
module mcpce_evsel
	import mcpce_pkg::*;
(
	input  mcpce_ctl_t    ctl,
	input  mcpce_status_t st,
	output logic          cond
);

	// Bank filter: single bank, every bank, or a group of four consecutive banks.
	function automatic logic bank_hit(input logic [7:0] um, input logic [3:0] bank);
		logic [7:0] grp;
		grp = um - MCPCE_BANK_GROUP_SEL;
		if (um <= MCPCE_UM_BANK_LAST)
			bank_hit = (bank == um[3:0]);
		else if (um == MCPCE_EVERY_BANK_SEL)
			bank_hit = 1'b1;
		else if (um <= MCPCE_UM_GROUP_LAST)
			bank_hit = (bank[3:2] == grp[1:0]);
		else
			bank_hit = 1'b0;
	endfunction

	// Pure decode; anything without a matching code yields a low condition.
	always_comb
	begin
		cond = 1'b0;
		case (ctl.code)
			// Any selected rank with clock enable on counts once; power-down flavours are alike.
			MCPCE_EV_CKE: cond = |(st.cke_on & ctl.umask);
			// Blocked cycles under critical throttling, no rank filter.
			MCPCE_EV_CRIT: cond = st.crit_throttle;
			MCPCE_EV_LIMIT: cond = st.power_ctrl_limit_event;
			// Only reachable while the clock runs, so clock-stopped refresh is never seen.
			MCPCE_EV_SELFREF: cond = st.self_refresh_clk;
			// Thermal or power-controller throttle, OR over selected ranks.
			MCPCE_EV_THROT: cond = |(st.throttle_rank & ctl.umask);
			MCPCE_EV_PREEMPT: cond = (st.rd_preempts_rd & ctl.umask[MCPCE_READ_OVER_READ_SEL])
				| (st.rd_preempts_wr & ctl.umask[MCPCE_READ_OVER_WRITE_SEL]);
			// Miss and timer causes ignore auto-precharge commands.
			MCPCE_EV_PRE: cond = st.pre_strobe & ((|(st.pre_cause[1:0] & ctl.umask[1:0])
				& ~st.pre_auto) | |(st.pre_cause[4:2] & ctl.umask[4:2]));
			MCPCE_EV_PRIO: cond = st.cas_strobe & |(st.cas_prio & ctl.umask[3:0]);
			default:
			begin
				// One code per rank, rank number in the low three bits.
				if (ctl.code[7:3] == MCPCE_EV_RANK0[7:3])
					cond = st.cas_strobe & (st.cas_rank == ctl.code[2:0])
						& bank_hit(ctl.umask, st.cas_bank);
			end
		endcase
	end

endmodule

// ### verilog/mcpce_cnt.sv
// One general counter with enable, edge detect and invert, preloadable from the bus.
`timescale 1ns/1ns
module mcpce_cnt
	import mcpce_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  mcpce_ctl_t       ctl,
	input  wire logic        cond,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	output logic [31:0]      cnt_r
);

	logic lvl;         // Condition after optional invert.
	logic lvl_prev_r;  // Last cycle's level for edge detect.
	logic hit;         // Adds one this cycle.

	// Invert first, then edge detect; the pair together is left to software to avoid.
	assign lvl = cond ^ ctl.inv;
	assign hit = ctl.en & lvl & (~ctl.edge_det | ~lvl_prev_r);

	// Level history runs every cycle so edge detect is clean right after enabling.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			lvl_prev_r <= 1'b0;
		else
			lvl_prev_r <= lvl;
	end

	// A bus write wins over a count in the same cycle; at most one is added per cycle.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			cnt_r <= MCPCE_CNT_RST;
		else if (wr_en)
			cnt_r <= wr_data;
		else if (hit)
			cnt_r <= cnt_r + 32'h0000_0001;
	end

endmodule

// ### verilog/mcpce_event_counter.sv
// Top of the controller event counter: bus slave, control words and four counters.
//
// Summary of operation
// - Rank CKE-on cycles, one-hot rank mask
// - Several active ranks still add one
// - All power-down flavours counted alike
// - Count critical throttle cycles, no rank filter
// - Critical throttle blocks traffic; count those cycles
// - Self-refresh counted only while clock runs
// - Thermal or power throttle, cause not shown
// - Several throttled ranks still add one
// - Throttle rank filter in unit mask
// - Preemption: read-over-read, read-over-write select bits
// - Precharge by read, write, fast path
// - Page-miss precharge excludes auto and timer
// - Timer-close precharge excludes auto-precharge
// - Read column priority low to starved
// - One event code per rank
// - Bank value, every bank or group
// - These events only on counters 0-3
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
module mcpce_event_counter
	import mcpce_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  mcpce_status_t    mc_status,
	input  wire logic [5:0]  avs_address,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);

	logic              ack_r;          // High in the answer cycle of a request.
	logic              req;            // A read or write is presented.
	logic              wr_eff;         // Write takes effect at this edge.
	logic              in_map;         // Address decodes to a register.
	logic              is_ctr;         // Counter half of the map.
	logic [1:0]        idx;            // Register index within a half.
	logic [31:0]       readdata_r;     // Registered read answer.
	logic [31:0]       rd_mux;         // Read value selected by address.
	logic [31:0]       ctl_word_r [MCPCE_NUM_CNT]; // Stored control words.
	logic [31:0]       cnt_val [MCPCE_NUM_CNT];    // Counter values.
	mcpce_ctl_t        ctl [MCPCE_NUM_CNT];        // Decoded control words.
	logic              cond [MCPCE_NUM_CNT];       // Per-counter event condition.

	// Merge write data into an old word under the byte enables.
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				res[b*8 +: 8] = nw[b*8 +: 8];
		end
		be_merge = res;
	endfunction

	// Unpack a control word into its fields.
	function automatic mcpce_ctl_t to_ctl(input logic [31:0] w);
		mcpce_ctl_t c;
		c.code     = w[MCPCE_CODE_LSB +: 8];
		c.umask    = w[MCPCE_UMASK_LSB +: 8];
		c.edge_det = w[MCPCE_EDGE_BIT];
		c.en       = w[MCPCE_EN_BIT];
		c.inv      = w[MCPCE_INV_BIT];
		to_ctl = c;
	endfunction

	// Address decode: aligned words below the end offset only.
	assign in_map = (avs_address < MCPCE_OFS_END) && (avs_address[1:0] == 2'b00);
	assign is_ctr = (avs_address >= MCPCE_OFS_CTR0);
	assign idx    = avs_address[3:2];
	assign req    = avs_read | avs_write;

	// Every request waits exactly one cycle; the answer edge is the second one.
	assign avs_waitrequest = req & ~ack_r;
	assign wr_eff          = avs_write & ack_r;
	assign avs_readdata    = readdata_r;

	// Answer flag toggles high for one cycle per request, then drops so the next one waits too.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// Read mux; unmapped or unaligned addresses read as zero.
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (in_map)
		begin
			if (is_ctr)
				rd_mux = cnt_val[idx];
			else
				rd_mux = ctl_word_r[idx];
		end
	end

	// Read data is captured in the wait cycle so it stands at the answer edge.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			readdata_r <= 32'h0000_0000;
		else if (avs_read & ~ack_r)
			readdata_r <= rd_mux;
	end

	// Control words; unimplemented bits stay zero and a new code applies from the next cycle.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < MCPCE_NUM_CNT; i++)
				ctl_word_r[i] <= MCPCE_CTL_RST;
		end
		else if (wr_eff && in_map && !is_ctr)
			ctl_word_r[idx] <= be_merge(ctl_word_r[idx], avs_writedata,
				avs_byteenable) & MCPCE_CTL_WMASK;
	end

	// Only four general counters exist, so the events live on counters 0 to 3.
	for (genvar g = 0; g < MCPCE_NUM_CNT; g++)
	begin : g_cnt
		assign ctl[g] = to_ctl(ctl_word_r[g]);

		mcpce_evsel u_evsel
		(
			.ctl  (ctl[g]),
			.st   (mc_status),
			.cond (cond[g])
		);

		mcpce_cnt u_cnt
		(
			.sys_clk (sys_clk),
			.reset_n (reset_n),
			.ctl     (ctl[g]),
			.cond    (cond[g]),
			.wr_en   (wr_eff && in_map && is_ctr && (idx == 2'(g))),
			.wr_data (be_merge(cnt_val[g], avs_writedata, avs_byteenable)),
			.cnt_r   (cnt_val[g])
		);
	end

	// Helper terms for the checks below, all on counter 0.
	logic        plain0;   // Counter 0 enabled, no invert and no edge detect.
	logic        quiet0;   // No bus write takes effect at this edge, to any register.
	logic [31:0] delta0;   // Change of counter 0 over the last edge.
	logic [31:0] prev0_r;  // Counter 0 as it stood before the last edge.

	assign plain0 = ctl[0].en & ~ctl[0].inv & ~ctl[0].edge_det;
	assign quiet0 = ~wr_eff;
	assign delta0 = cnt_val[0] - prev0_r;

	// History of counter 0, kept in a flop so the difference needs no sampled-value call.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			prev0_r <= MCPCE_CNT_RST;
		else
			prev0_r <= cnt_val[0];
	end

	// Rank clock-enable event adds one for a selected active rank.
	AST_CKE_ADDS: assert property (@(posedge sys_clk) disable iff (!reset_n)
		plain0 && quiet0 && ctl[0].code == MCPCE_EV_CKE
		&& |(mc_status.cke_on & ctl[0].umask)
		|=> cnt_val[0] == $past(cnt_val[0]) + 32'h0000_0001)
		else $error("rank clock-enable cycle not counted");

	// Never more than one added per cycle, whatever the rank count.
	AST_ONE_PER_CYCLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		quiet0 |=> (delta0 == 32'h0000_0000) || (delta0 == 32'h0000_0001))
		else $error("counter moved by more than one");

	// Critical throttle cycles counted for a run of three cycles.
	AST_CRIT_RUN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(plain0 && quiet0 && ctl[0].code == MCPCE_EV_CRIT && mc_status.crit_throttle) [*3]
		|=> cnt_val[0] == $past(cnt_val[0], 3) + 32'h0000_0003)
		else $error("critical throttle run miscounted");

	// Self-refresh with clock running is counted.
	AST_SELFREF: assert property (@(posedge sys_clk) disable iff (!reset_n)
		plain0 && quiet0 && ctl[0].code == MCPCE_EV_SELFREF && mc_status.self_refresh_clk
		|=> $changed(cnt_val[0]))
		else $error("self-refresh cycle not counted");

	// Throttled ranks outside the mask never count.
	AST_THROT_MASK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		plain0 && quiet0 && ctl[0].code == MCPCE_EV_THROT
		&& (mc_status.throttle_rank & ctl[0].umask) == 8'h00
		|=> $stable(cnt_val[0]))
		else $error("unselected rank throttle counted");

	// Read-over-write preemption counts only when its select bit is set.
	AST_PREEMPT_WR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		plain0 && quiet0 && ctl[0].code == MCPCE_EV_PREEMPT && mc_status.rd_preempts_wr
		&& !mc_status.rd_preempts_rd
		|=> delta0 == {31'h0000_0000, $past(ctl[0].umask[MCPCE_READ_OVER_WRITE_SEL])})
		else $error("read-over-write preemption miscounted");

	// Auto-precharge is never a page-miss precharge.
	AST_MISS_NO_AUTO: assert property (@(posedge sys_clk) disable iff (!reset_n)
		plain0 && quiet0 && ctl[0].code == MCPCE_EV_PRE && ctl[0].umask == 8'h01
		&& mc_status.pre_auto
		|=> $stable(cnt_val[0]))
		else $error("auto-precharge counted as page miss");

	// Every-bank selection counts any read column command to the chosen rank.
	AST_EVERY_BANK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		plain0 && quiet0 && ctl[0].code[7:3] == MCPCE_EV_RANK0[7:3]
		&& ctl[0].umask == MCPCE_EVERY_BANK_SEL && mc_status.cas_strobe
		&& mc_status.cas_rank == ctl[0].code[2:0]
		|=> delta0 == 32'h0000_0001)
		else $error("every-bank read column not counted");

	// An unknown code counts nothing while invert is clear.
	AST_NO_MATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
		quiet0 && ctl[0].code == 8'h00 |=> $stable(cnt_val[0]))
		else $error("counter moved without a matching code");

	// Bus answers one cycle after a request appears.
	AST_BUS_WAIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		req && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held for more than one cycle");

endmodule

// ### verification/mcpce_mc_model.sv
// Stand-in for the controller scheduler: replays a requested status pattern, else idles.
`timescale 1ns/1ns
module mcpce_mc_model
	import mcpce_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    reset_n,
	input  wire logic    drive_on,
	input  mcpce_status_t drive_st,
	output mcpce_status_t mc_status
);
	// Last pattern shown, so idle cycles can show its inverse instead of stale qualifiers.
	mcpce_status_t last_r;

	// One register stage: a pattern asked for after edge e is shown from edge e+1.
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			mc_status <= '0;
			last_r    <= '0;
		end
		else if (drive_on)
		begin
			mc_status <= drive_st;
			last_r    <= drive_st;
			// Critical throttle blocks all traffic, so no command strobe can appear.
			if (drive_st.crit_throttle)
			begin
				mc_status.cas_strobe     <= 1'b0;
				mc_status.pre_strobe     <= 1'b0;
				mc_status.rd_preempts_rd <= 1'b0;
				mc_status.rd_preempts_wr <= 1'b0;
			end
		end
		else
		begin
			// Idle: levels and strobes drop, qualifiers flip so old values never look valid.
			mc_status           <= '0;
			mc_status.pre_cause <= ~last_r.pre_cause;
			mc_status.pre_auto  <= ~last_r.pre_auto;
			mc_status.cas_prio  <= ~last_r.cas_prio;
			mc_status.cas_rank  <= ~last_r.cas_rank;
			mc_status.cas_bank  <= ~last_r.cas_bank;
		end
	end
endmodule

// ### verification/testbench.sv
// Self-checking bench: programs each event, replays controller status and reads the counts.
`timescale 1ns/1ns
module testbench;
	import mcpce_pkg::*;
	logic          sys_clk = 1'b0;         // Bench clock, 100 ns period.
	logic          reset_n = 1'b0;         // Synchronous reset, active low.
	logic [5:0]    avs_address = '0;       // Bus request signals, idle at time zero.
	logic [3:0]    avs_byteenable = 4'hF;  // Whole words only.
	logic          avs_read = 1'b0;
	logic          avs_write = 1'b0;
	logic [31:0]   avs_writedata = '0;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic          drive_on = 1'b0;        // Asks the model to replay drive_st.
	mcpce_status_t drive_st = '0;
	mcpce_status_t mc_status;
	logic [31:0]   exp_q[$];               // Expected read data, oldest first.
	int            n_errors = 0;
	int            cmp_count = 0;
	int            cycles = 0;
	int            n_case = 0;             // Picks the counter, rotating over all four.
	int            tbl[5] = '{15, 16, 17, 20, 21};  // Bank value boundaries.

	// Free-running clock.
	always #50 sys_clk = ~sys_clk;

	mcpce_event_counter uut (.sys_clk(sys_clk), .reset_n(reset_n), .mc_status(mc_status),
		.avs_address(avs_address), .avs_byteenable(avs_byteenable), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	mcpce_mc_model model (.sys_clk(sys_clk), .reset_n(reset_n), .drive_on(drive_on),
		.drive_st(drive_st), .mc_status(mc_status));

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("Errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Compares one read word against its note.
	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	// Holds the request until waitrequest is low before a rising edge, releases after it.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		@(negedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(negedge sys_clk);
		@(posedge sys_clk);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		// A spare edge keeps back-to-back calls from driving a strobe twice in one step.
		@(posedge sys_clk);
	endtask

	// Notes the expected word, then reads it.
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, '0);
	endtask

	// One case: program and clear a counter, replay the status k cycles, read both back.
	task automatic tc(input logic [7:0] code, input logic [7:0] um, input mcpce_status_t st,
		input logic hit, input logic edg = 1'b0);
		logic [5:0]  ofs;
		logic [31:0] ctl;
		int          k;
		ofs = {2'b00, 2'(n_case % 4), 2'b00};
		ctl = {8'h00, edg ? 8'h44 : 8'h40, um, code};  // Invert never set with edge.
		k = $urandom_range(4, 1);
		n_case++;
		bus(1'b1, MCPCE_OFS_CTL0 + ofs, ctl);
		bus(1'b1, MCPCE_OFS_CTR0 + ofs, '0);
		drive_st <= st;
		drive_on <= 1'b1;
		repeat (k) @(posedge sys_clk);
		drive_on <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rd(MCPCE_OFS_CTR0 + ofs, hit ? (edg ? 32'h0000_0001 : 32'(k)) : '0);
		rd(MCPCE_OFS_CTL0 + ofs, ctl & MCPCE_CTL_WMASK);
	endtask

	// Cuts a hang short; the whole run needs under 2000 cycles.
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			n_errors++;
			stop_test();
		end
	end

	// Monitor: each completed read takes the oldest note off the queue.
	always @(posedge sys_clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			check(exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF, avs_readdata);

	// Main sequence.
	initial
	begin
		logic [7:0] u;
		logic [3:0] b;
		logic [2:0] r;
		logic [2:0] rr;
		void'($urandom(32'h38ca_e7b2));
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// Unmapped and unaligned places read zero.
		rd(6'h20, '0);
		rd(6'h02, '0);
		tc(MCPCE_EV_CKE, 8'h01, '{cke_on: 8'h01, default: '0}, 1'b1);
		tc(MCPCE_EV_CKE, 8'h80, '{cke_on: 8'h7F, default: '0}, 1'b0);
		tc(MCPCE_EV_CKE, 8'hFF, '{cke_on: 8'hFF, default: '0}, 1'b1);
		tc(MCPCE_EV_CRIT, 8'h00, '{crit_throttle: 1'b1, default: '0}, 1'b1);
		tc(MCPCE_EV_CRIT, 8'hFF, '{throttle_rank: 8'hFF, default: '0}, 1'b0);
		// Edge detect turns a whole throttle run into a single count.
		tc(MCPCE_EV_CRIT, 8'h00, '{crit_throttle: 1'b1, default: '0}, 1'b1, 1'b1);
		tc(MCPCE_EV_LIMIT, 8'h00, '{power_ctrl_limit_event: 1'b1, default: '0}, 1'b1);
		tc(MCPCE_EV_SELFREF, 8'h00, '{self_refresh_clk: 1'b1, default: '0}, 1'b1);
		tc(MCPCE_EV_THROT, 8'h82, '{throttle_rank: 8'h82, default: '0}, 1'b1);
		tc(MCPCE_EV_THROT, 8'hFE, '{throttle_rank: 8'h01, default: '0}, 1'b0);
		tc(MCPCE_EV_PREEMPT, 8'h01, '{rd_preempts_rd: 1'b1, default: '0}, 1'b1);
		tc(MCPCE_EV_PREEMPT, 8'h01, '{rd_preempts_wr: 1'b1, default: '0}, 1'b0);
		tc(MCPCE_EV_PREEMPT, 8'h02, '{rd_preempts_wr: 1'b1, default: '0}, 1'b1);
		tc(8'h84, 8'hFF, '{cke_on: 8'hFF, default: '0}, 1'b0);
		// Every precharge cause, with and without auto-precharge, and a wrong cause.
		for (int i = 0; i < 5; i++)
		begin
			for (int a = 0; a < 2; a++)
				tc(MCPCE_EV_PRE, 8'(1 << i), '{pre_strobe: 1'b1, pre_cause: 5'(1 << i),
					pre_auto: a[0], default: '0}, !(a == 1 && i < 2));
			tc(MCPCE_EV_PRE, 8'(1 << i), '{pre_strobe: 1'b1, pre_cause: 5'(1 << ((i + 1) % 5)),
				default: '0}, 1'b0);
		end
		// Every priority, selected and masked out.
		for (int i = 0; i < 4; i++)
		begin
			tc(MCPCE_EV_PRIO, 8'(1 << i), '{cas_strobe: 1'b1, cas_prio: 4'(1 << i),
				default: '0}, 1'b1);
			tc(MCPCE_EV_PRIO, 8'(~(1 << i) & 15), '{cas_strobe: 1'b1, cas_prio: 4'(1 << i),
				default: '0}, 1'b0);
		end
		// Per-rank codes with bank values, boundaries first, then random.
		for (int i = 0; i < 16; i++)
		begin
			r = 3'($urandom_range(7));
			rr = $urandom_range(1) ? r : r + 3'd1;
			b = 4'($urandom);
			u = (i < 5) ? 8'(tbl[i]) : 8'($urandom_range(21));
			tc(MCPCE_EV_RANK0 + 8'(r), u, '{cas_strobe: 1'b1, cas_prio: 4'h1, cas_rank: rr,
				cas_bank: b, default: '0}, rr == r && ((u < 8'd16) ? (b == u[3:0]) :
				(u == 8'd16 || (u <= 8'd20 && b[3:2] == 2'(u - 8'd17)))));
		end
		stop_test();
	end
endmodule
